// [common/hdr_params.svh]
// Offsets, field positions, reset values and timing counts of the HDR exposure sequencer.
// Assumes an includer that wants plain macros; holds definitions only.
`ifndef HDR_PARAMS_SVH
`define HDR_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address is four times the index)
`define HDR_IDX_COLOR    7'h27
`define HDR_IDX_MODE     7'h29
`define HDR_IDX_PRI      7'h2a
`define HDR_IDX_KP1      7'h30
`define HDR_IDX_KP2      7'h33
`define HDR_IDX_SLOPES   7'h36
`define HDR_IDX_SEC      7'h38
`define HDR_IDX_FOT      7'h49
`define HDR_IDX_CLAMP2   7'h59
`define HDR_IDX_CLAMP3   7'h5a
`define HDR_IDX_STATUS   7'h64

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define HDR_BIT_EXT_SRC    0
`define HDR_BIT_INTERLEAVE 1
`define HDR_BIT_CLAMP_EN   6

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define HDR_RST_COLOR    1'b1
`define HDR_RST_INTERL   1'b0
`define HDR_RST_EXT_SRC  1'b0
`define HDR_RST_EXPO     24'h000800
`define HDR_RST_KNEE     24'h000001
`define HDR_RST_SLOPES   2'h1
`define HDR_RST_CLAMP    7'h60
`define HDR_RST_FOT      8'h0a

////////////////////////////////////////////////////////////////////////////////
// Timing: one count is 129 master clocks, overhead term weighs 43/100
`define HDR_UNIT_CYC     129
`define HDR_OVL_NUM      43
`define HDR_OVL_DEN      100
`define HDR_KNEE_HOLD    129

`endif

// [common/hdr_pkg.sv]
// Types shared by the HDR exposure sequencer and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package hdr_pkg;

  // Sequencer state of one frame
  typedef enum logic [1:0] {
    HDR_IDLE,
    HDR_HOLD,
    HDR_SETTLE,
    HDR_RUN
  } hdr_state_t;

  // Pins driven by the camera controller
  typedef struct packed {
    logic frame_request;
    logic even_exposure_trigger;
    logic odd_exposure_trigger;
  } hdr_pins_t;

  // Exposure control towards the pixel array
  typedef struct packed {
    logic       even_integrate;
    logic       odd_integrate;
    logic       clamp_active;
    logic [5:0] clamp_level;
    logic       exposure_done;
    logic       bayer_pairing;
  } hdr_expo_t;

endpackage : hdr_pkg

// [design/hdr_exp_timer.sv]
// One exposure countdown, used once per row parity.
// Assumes start and load are one-cycle pulses from the sequencer.
module hdr_exp_timer
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Control
  input  wire logic        start_in,
  input  wire logic        load_in,
  input  wire logic [31:0] len_in,
  // State
  output logic             active_out,
  output logic [31:0]      remain_out
);

  logic counting;

  ////////////////////////////////////////////////////////////////////////////
  // Start opens an open-ended exposure; load gives it a fixed remainder
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      active_out <= 1'b0;
      counting   <= 1'b0;
      remain_out <= 32'h0;
    end
    else if (load_in)
    begin
      active_out <= 1'b1;
      counting   <= 1'b1;
      remain_out <= (len_in == 32'h0) ? 32'h1 : len_in; // Never shorter than a cycle
    end
    else if (start_in)
    begin
      active_out <= 1'b1;
      counting   <= 1'b0;
    end
    else if (counting)
    begin
      if (remain_out == 32'h1)
      begin
        active_out <= 1'b0;
        counting   <= 1'b0;
      end
      remain_out <= remain_out - 32'h1;
    end
  end

endmodule : hdr_exp_timer

// [design/hdr_exposure_sequencer.sv]
// Exposure sequencer with interleaved and piecewise linear HDR control.
// Assumes an Avalon-MM master and synchronous controller pins on clk_in.
//
// Behaviour
// - Register 41 bit 1 enables interleaved exposure, reset 0.
// - Interleaved internal: even rows last 129 clocks times (0.43*overhead + primary).
// - Interleaved internal: odd rows use the same formula with the secondary count.
// - External interleaved: even trigger times even rows, odd trigger odd rows.
// - Interleaved mode works with internal and external sources; piecewise mode with internal only.
// - Register 39 bit 0 selects colour (0) or mono (1), reset 1.
// - Piecewise mode changes clipping level at most twice, three slopes at most.
// - Register 54 bits 1:0 hold the slope count, reset 1, valid 1 to 3.
// - First knee timed by formula with kneepoint1 count, registers 48-50, reset 1.
// - Second knee timed by formula with kneepoint2 count, registers 51-53, reset 1.
// - Register 90 bits 6:0 third clamp, reset 96, bit 6 enable.
// - Register 89 bits 6:0 second clamp, reset 96, bit 6 enable.
// - Piecewise internal exposure length is the primary count.
// - Bright pixels are held at the clamp for a set time, at most twice.
// - Knee level from clamp settings, segment slope from knee durations.
// - Register 41 bit 0 picks count (0) or trigger-to-request interval (1).
// - Overhead term in every formula comes from register 73.
//
// The Avalon-MM slave port was left to the implementer.
`include "hdr_params.svh"

module hdr_exposure_sequencer
#(
  parameter int KNEE_HOLD = `HDR_KNEE_HOLD
)
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  // Avalon-MM slave
  input  wire logic [8:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // Controller pins
  input  wire hdr_pkg::hdr_pins_t pins_in,
  // Pixel array control
  output hdr_pkg::hdr_expo_t     expo_out
);
  import hdr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic             color_filter_select;
  logic             interleave_enable;
  logic             ext_source;
  logic [23:0]      primary_exposure_count;
  logic [23:0]      secondary_exposure_count;
  logic [23:0]      kneepoint1_count;
  logic [23:0]      kneepoint2_count;
  logic [1:0]       slope_count;
  logic [6:0]       clamp_level_second;
  logic [6:0]       clamp_level_third;
  logic [7:0]       frame_overhead_length;
  logic [6:0]       idx;
  logic             req;
  logic             write_go;
  logic [7:0]       wd;
  logic [7:0]       rd_byte;
  hdr_pins_t        pins_q;
  logic             req_rise;
  logic             even_rise;
  logic             odd_rise;
  hdr_state_t       state;
  hdr_state_t       next_state;
  logic             even_start;
  logic             odd_start;
  logic             even_load;
  logic             odd_load;
  logic [31:0]      even_len;
  logic [31:0]      odd_len;
  logic             even_act;
  logic             odd_act;
  logic [31:0]      even_remain;
  logic [31:0]      overlap_len;
  logic [31:0]      kp1_len;
  logic [31:0]      kp2_len;
  logic [1:0]       knee_num;
  logic [15:0]      hold_cnt;
  logic [5:0]       hold_level;
  logic             piecewise;

  // Cycles of the overhead overlap term
  function automatic logic [31:0] ovl_f(input logic [7:0] f);
    logic [31:0] p;
    p = 32'(f) * 32'(`HDR_UNIT_CYC * `HDR_OVL_NUM);
    return p / 32'(`HDR_OVL_DEN);
  endfunction : ovl_f

  // Cycles of a whole exposure formula
  function automatic logic [31:0] dur_f(input logic [23:0] c, input logic [7:0] f);
    return 32'(c) * 32'(`HDR_UNIT_CYC) + ovl_f(f);
  endfunction : dur_f

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the answer
  assign idx      = avs_address_in[8:2];
  assign req      = avs_read_in | avs_write_in;
  assign write_go = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
  assign wd       = avs_writedata_in[7:0];

  // Waitrequest drops for the one cycle in which the master completes
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
  end

  // Read data captured as waitrequest drops, held until the next read answer
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      avs_readdata_out <= 32'h0;
    else if (avs_read_in & avs_waitrequest_out)
      avs_readdata_out <= {24'h0, rd_byte};
  end

  // Read decode; unmapped indices read zero
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (idx)
      `HDR_IDX_COLOR:      rd_byte = {7'h0, color_filter_select};
      `HDR_IDX_MODE:       rd_byte = {6'h0, interleave_enable, ext_source};
      `HDR_IDX_PRI:        rd_byte = primary_exposure_count[7:0];
      `HDR_IDX_PRI + 7'h1: rd_byte = primary_exposure_count[15:8];
      `HDR_IDX_PRI + 7'h2: rd_byte = primary_exposure_count[23:16];
      `HDR_IDX_KP1:        rd_byte = kneepoint1_count[7:0];
      `HDR_IDX_KP1 + 7'h1: rd_byte = kneepoint1_count[15:8];
      `HDR_IDX_KP1 + 7'h2: rd_byte = kneepoint1_count[23:16];
      `HDR_IDX_KP2:        rd_byte = kneepoint2_count[7:0];
      `HDR_IDX_KP2 + 7'h1: rd_byte = kneepoint2_count[15:8];
      `HDR_IDX_KP2 + 7'h2: rd_byte = kneepoint2_count[23:16];
      `HDR_IDX_SLOPES:     rd_byte = {6'h0, slope_count};
      `HDR_IDX_SEC:        rd_byte = secondary_exposure_count[7:0];
      `HDR_IDX_SEC + 7'h1: rd_byte = secondary_exposure_count[15:8];
      `HDR_IDX_SEC + 7'h2: rd_byte = secondary_exposure_count[23:16];
      `HDR_IDX_FOT:        rd_byte = frame_overhead_length;
      `HDR_IDX_CLAMP2:     rd_byte = {1'b0, clamp_level_second};
      `HDR_IDX_CLAMP3:     rd_byte = {1'b0, clamp_level_third};
      `HDR_IDX_STATUS:     rd_byte = {1'b0, hold_cnt != 16'h0, knee_num,
                                      odd_act, even_act, state};
      default:             rd_byte = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file; a write lands on the edge the master completes on
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      color_filter_select      <= `HDR_RST_COLOR;
      interleave_enable        <= `HDR_RST_INTERL;
      ext_source               <= `HDR_RST_EXT_SRC;
      primary_exposure_count   <= `HDR_RST_EXPO;
      secondary_exposure_count <= `HDR_RST_EXPO;
      kneepoint1_count         <= `HDR_RST_KNEE;
      kneepoint2_count         <= `HDR_RST_KNEE;
      slope_count              <= `HDR_RST_SLOPES;
      clamp_level_second       <= `HDR_RST_CLAMP;
      clamp_level_third        <= `HDR_RST_CLAMP;
      frame_overhead_length    <= `HDR_RST_FOT;
    end
    else if (write_go)
    begin
      // Byte lanes: lowest index is the least significant byte
      case (idx)
        `HDR_IDX_COLOR:      color_filter_select <= wd[0];
        `HDR_IDX_MODE:
        begin
          ext_source        <= wd[`HDR_BIT_EXT_SRC];
          interleave_enable <= wd[`HDR_BIT_INTERLEAVE];
        end
        `HDR_IDX_PRI:        primary_exposure_count[7:0]    <= wd;
        `HDR_IDX_PRI + 7'h1: primary_exposure_count[15:8]   <= wd;
        `HDR_IDX_PRI + 7'h2: primary_exposure_count[23:16]  <= wd;
        `HDR_IDX_KP1:        kneepoint1_count[7:0]          <= wd;
        `HDR_IDX_KP1 + 7'h1: kneepoint1_count[15:8]         <= wd;
        `HDR_IDX_KP1 + 7'h2: kneepoint1_count[23:16]        <= wd;
        `HDR_IDX_KP2:        kneepoint2_count[7:0]          <= wd;
        `HDR_IDX_KP2 + 7'h1: kneepoint2_count[15:8]         <= wd;
        `HDR_IDX_KP2 + 7'h2: kneepoint2_count[23:16]        <= wd;
        `HDR_IDX_SLOPES:     slope_count <= wd[1:0];
        `HDR_IDX_SEC:        secondary_exposure_count[7:0]  <= wd;
        `HDR_IDX_SEC + 7'h1: secondary_exposure_count[15:8] <= wd;
        `HDR_IDX_SEC + 7'h2: secondary_exposure_count[23:16] <= wd;
        `HDR_IDX_FOT:        frame_overhead_length <= wd;
        `HDR_IDX_CLAMP2:     clamp_level_second <= wd[6:0];
        `HDR_IDX_CLAMP3:     clamp_level_third  <= wd[6:0];
        default:             ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin edges; pins arrive synchronous so one stage suffices
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      pins_q <= '0;
    else
      pins_q <= pins_in;
  end

  assign req_rise  = pins_in.frame_request & ~pins_q.frame_request;
  assign even_rise = pins_in.even_exposure_trigger & ~pins_q.even_exposure_trigger;
  assign odd_rise  = pins_in.odd_exposure_trigger & ~pins_q.odd_exposure_trigger;

  ////////////////////////////////////////////////////////////////////////////
  // Exposure lengths in clocks
  assign overlap_len = ovl_f(frame_overhead_length);
  assign kp1_len     = dur_f(kneepoint1_count, frame_overhead_length);
  assign kp2_len     = dur_f(kneepoint2_count, frame_overhead_length);

  // Odd rows take their own count only while interleaving
  always_comb
  begin
    even_len = dur_f(primary_exposure_count, frame_overhead_length);
    odd_len  = even_len;
    if (interleave_enable)
      odd_len = dur_f(secondary_exposure_count, frame_overhead_length);
    if (ext_source)
    begin
      even_len = overlap_len;
      odd_len  = overlap_len;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequence
  always_comb
  begin
    next_state = state;
    even_start = 1'b0;
    odd_start  = 1'b0;
    even_load  = 1'b0;
    odd_load   = 1'b0;
    unique case (state)
      HDR_IDLE:
        if (!ext_source && req_rise)
        begin
          even_load  = 1'b1;
          odd_load   = 1'b1;
          next_state = HDR_SETTLE;
        end
        else if (ext_source && (even_rise || (interleave_enable && odd_rise)))
        begin
          even_start = even_rise | (odd_rise & ~interleave_enable);
          odd_start  = interleave_enable ? odd_rise : even_rise;
          next_state = HDR_HOLD;
        end
      HDR_HOLD:
      begin
        // The other parity may still be triggered before the request
        even_start = even_rise & ~even_act;
        odd_start  = interleave_enable & odd_rise & ~odd_act;
        if (req_rise)
        begin
          even_load  = even_act | even_start;
          odd_load   = odd_act | odd_start;
          next_state = HDR_SETTLE;
        end
      end
      HDR_SETTLE:
        next_state = HDR_RUN;
      HDR_RUN:
        if (!even_act && !odd_act)
          next_state = HDR_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      state <= HDR_IDLE;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Even and odd row exposure timers
  hdr_exp_timer u_even
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (even_start),
    .load_in    (even_load),
    .len_in     (even_len),
    .active_out (even_act),
    .remain_out (even_remain)
  );

  hdr_exp_timer u_odd
  (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (odd_start),
    .load_in    (odd_load),
    .len_in     (odd_len),
    .active_out (odd_act),
    .remain_out ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Kneepoints: only in internal mode, where the total length is known
  // Slope count 0 is invalid and behaves as a single slope
  assign piecewise = ~ext_source & (slope_count >= 2'h2);

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      knee_num   <= 2'h0;
      hold_cnt   <= 16'h0;
      hold_level <= 6'h0;
    end
    else if (state != HDR_RUN)
    begin
      knee_num <= 2'h0;
      hold_cnt <= 16'h0;
    end
    else
    begin
      if (hold_cnt != 16'h0)
        hold_cnt <= hold_cnt - 16'h1;
      // Knee 1 when the remaining time equals the first knee duration
      if (piecewise && knee_num == 2'h0 && even_remain == kp1_len)
      begin
        knee_num <= 2'h1;
        if (clamp_level_second[`HDR_BIT_CLAMP_EN])
        begin
          hold_cnt   <= 16'(KNEE_HOLD);
          hold_level <= clamp_level_second[5:0];
        end
      end
      else if (piecewise && slope_count == 2'h3 && knee_num == 2'h1
               && even_remain == kp2_len)
      begin
        knee_num <= 2'h2;
        if (clamp_level_third[`HDR_BIT_CLAMP_EN])
        begin
          hold_cnt   <= 16'(KNEE_HOLD);
          hold_level <= clamp_level_third[5:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs towards the array
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      expo_out <= '0;
    else
    begin
      expo_out.even_integrate <= even_act;
      expo_out.odd_integrate  <= odd_act;
      expo_out.clamp_active   <= hold_cnt != 16'h0;
      expo_out.clamp_level    <= hold_level;
      expo_out.exposure_done  <= state == HDR_RUN && !even_act && !odd_act;
      // Colour sensors pair rows so the Bayer pattern stays intact
      expo_out.bayer_pairing  <= interleave_enable & ~color_filter_select;
    end
  end

endmodule : hdr_exposure_sequencer

// [tb/hdr_exposure_sequencer_sva.sv]
// Port checker for the HDR exposure sequencer.
// Assumes one clock domain; bound to the sequencer top below.
module hdr_seq_sva
#(
  parameter int KNEE_HOLD = 129
)
(
  // Clock and reset
  input wire logic               clk_in,
  input wire logic               sys_rst_in,
  // Register bus
  input wire logic               avs_read_in,
  input wire logic               avs_write_in,
  input wire logic [31:0]        avs_readdata_out,
  input wire logic               avs_waitrequest_out,
  // Pins and exposure control
  input wire hdr_pkg::hdr_pins_t pins_in,
  input wire hdr_pkg::hdr_expo_t expo_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import hdr_pkg::*;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  ////////////////////////////////////////
  // Length of the running clamp; a counter, since a knee hold is too long to unroll
  int unsigned hold_cnt;
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      hold_cnt <= 0;
    else if (expo_out.clamp_active)
      hold_cnt <= hold_cnt + 1;
    else
      hold_cnt <= 0;
  end

  ////////////////////////////////////////
  // Bus handshake, then exposure timing
  wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("bus request got no answer");
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property ($fell(avs_waitrequest_out)
    |-> $past(avs_read_in || avs_write_in)) else $error("answer without request");
  rdata_upper_a: assert property (avs_readdata_out[31:8] == 24'h0)
    else $error("read data above the byte lane");
  done_pulse_a: assert property (expo_out.exposure_done |=> !expo_out.exposure_done)
    else $error("exposure done longer than one cycle");
  done_quiet_a: assert property (expo_out.exposure_done
    |-> !(expo_out.even_integrate || expo_out.odd_integrate)) else $error("done while exposing");
  done_after_a: assert property ($fell(expo_out.even_integrate || expo_out.odd_integrate)
    |-> ##[0:3] expo_out.exposure_done) else $error("no done after exposure");
  clamp_hold_a: assert property ($fell(expo_out.clamp_active)
    |-> hold_cnt == KNEE_HOLD) else $error("clamp hold length wrong");
  clamp_inside_a: assert property ($rose(expo_out.clamp_active)
    |-> expo_out.even_integrate) else $error("clamp outside exposure");
  integ_cause_a: assert property ($rose(expo_out.even_integrate)
    |-> $past(pins_in.frame_request, 2) || $past(pins_in.even_exposure_trigger, 2))
    else $error("even exposure without a start pin");
endmodule : hdr_seq_sva

bind hdr_exposure_sequencer hdr_seq_sva #(.KNEE_HOLD(KNEE_HOLD)) sva_u (.clk_in(clk_in),
  .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .pins_in(pins_in), .expo_out(expo_out));

// [tb/hdr_ctrl_model.sv]
// Camera controller model driving the trigger and frame request pins.
// Assumes its tasks are called just after a rising clock edge.
module hdr_ctrl_model
(
  // Clock
  input  wire logic         clk_in,
  // Pins to the sequencer
  output hdr_pkg::hdr_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import hdr_pkg::*;

  // Pins idle low between frames
  initial pins_out = '0;

  ////////////////////////////////////////
  // One pin high for two cycles, then quiet for gap cycles
  task automatic pulse(input int sel, input int gap);
    @(posedge clk_in);
    pins_out[sel] <= 1'b1;
    repeat (2) @(posedge clk_in);
    pins_out[sel] <= 1'b0;
    repeat (gap) @(posedge clk_in);
  endtask : pulse

  // Even trigger, odd trigger after a lead, then the frame request
  task automatic ext_frame(input int even_lead, input int odd_lead);
    pulse(1, even_lead);
    pulse(0, odd_lead);
    pulse(2, 0);
  endtask : ext_frame
endmodule : hdr_ctrl_model

// [tb/testbench.sv]
// Self-checking bench for the HDR exposure sequencer.
// Assumes the controller model and the bound port checker.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import hdr_pkg::*;

  localparam int HOLD = 4;
  localparam logic [6:0] RIDX [17] = '{7'h27, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h30, 7'h31,
    7'h32, 7'h33, 7'h34, 7'h35, 7'h36, 7'h38, 7'h39, 7'h3a, 7'h59, 7'h5a};
  localparam logic [7:0] RRST [17] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00, 8'h08, 8'h00, 8'h60, 8'h60};
  localparam logic [7:0] RMSK [17] = '{8'h01, 8'h03, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'hff, 8'hff, 8'h03, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f};

  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [8:0]  avs_address_in = '0;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [3:0]  avs_byteenable_in = '0;
  logic [31:0] avs_readdata_out;
  logic        avs_waitrequest_out;
  hdr_pins_t   pins;
  hdr_expo_t   expo;
  logic [7:0]  q;
  logic [5:0]  last_level;
  logic        done_seen = 1'b0;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          even_len, odd_len, clamp_len;

  always #4 clk_in = ~clk_in;

  hdr_exposure_sequencer #(.KNEE_HOLD(HOLD)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .pins_in(pins), .expo_out(expo));
  hdr_ctrl_model ctl_u (.clk_in(clk_in), .pins_out(pins));

  ////////////////////////////////////////
  // Timeout and measurement of each frame's exposure and clamp cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      results();
    end
    if (expo.even_integrate === 1'b1) even_len++;
    if (expo.odd_integrate === 1'b1) odd_len++;
    if (expo.clamp_active === 1'b1) clamp_len++;
    if (expo.clamp_active === 1'b1) last_level = expo.clamp_level;
    if (expo.exposure_done === 1'b1) done_seen = 1'b1;
  end

  task automatic results;
    if (bad_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_count(input int got, input int exp);
    total_checks++;
    if (got != exp)
    begin
      bad_count++;
      $display("[ERR] %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask : check_count

  function automatic int expo_cycles(input int cnt, input int fot);
    int n;
    n = 129 * cnt + (5547 * fot) / 100;
    return (n < 1) ? 1 : n;
  endfunction : expo_cycles

  ////////////////////////////////////////
  // One bus transfer; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                     input logic [3:0] be);
    avs_address_in <= {idx, 2'b00};
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    avs_writedata_in <= 32'({$urandom, d});
    avs_byteenable_in <= be;
    do
      @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out[7:0];
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask : bus

  task automatic wr8(input logic [6:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1 | 4'($urandom));
  endtask : wr8

  task automatic rd(input logic [6:0] idx);
    bus(1'b0, idx, 8'($urandom), 4'($urandom));
  endtask : rd

  task automatic wr24(input logic [6:0] idx, input logic [23:0] v);
    for (int b = 0; b < 3; b++)
      wr8(idx + 7'(b), v[8*b +: 8]);
  endtask : wr24

  // Start a frame, internal or by triggers, and wait for its end
  task automatic frame(input int g1, input int g2, input logic ext);
    even_len = 0;
    odd_len = 0;
    clamp_len = 0;
    done_seen = 1'b0;
    if (ext)
      ctl_u.ext_frame(g1, g2);
    else
      ctl_u.pulse(2, 0);
    while (done_seen !== 1'b1)
      @(posedge clk_in);
    repeat (2) @(posedge clk_in);
  endtask : frame

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [7:0] v;
    logic [5:0] c2;
    logic [5:0] c3;
    int p, s, f, sl, n, g1, g2;
    void'($urandom(32'h1437));
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    // Reset values, then random bytes read back; a write without lane 0 is dropped
    for (int i = 0; i < 17; i++)
    begin
      rd(RIDX[i]);
      check_byte(q, RRST[i]);
    end
    for (int i = 0; i < 17; i++)
    begin
      v = 8'($urandom);
      wr8(RIDX[i], v);
      bus(1'b1, RIDX[i], ~v, 4'($urandom) & 4'he);
      rd(RIDX[i]);
      check_byte(q, v & RMSK[i]);
    end
    wr8(7'h10, 8'h5a);
    rd(7'h10);
    check_byte(q, 8'h00);
    // Row pairing follows interleave and colour select
    for (int i = 0; i < 4; i++)
    begin
      wr8(7'h27, 8'(i[0]));
      wr8(7'h29, 8'(i[1]) << 1);
      repeat (2) @(posedge clk_in);
      check_byte({7'h0, expo.bayer_pairing}, {7'h0, i[1] & ~i[0]});
    end
    // Internal frames, interleaved and not, random counts and overhead
    wr8(7'h36, 8'h1);
    for (int m = 0; m < 4; m++)
    begin
      p = 1 + $urandom % 3;
      s = 1 + $urandom % 3;
      f = (m == 3) ? 2 : $urandom % 3;
      wr8(7'h49, 8'(f));
      wr24(7'h2a, 24'(p));
      wr24(7'h38, 24'(s));
      wr8(7'h29, 8'(m % 2) << 1);
      frame(0, 0, 1'b0);
      check_count(even_len, expo_cycles(p, f));
      check_count(odd_len, expo_cycles((m % 2) ? s : p, f));
    end
    // Piecewise frames over every slope count; the last with third clamp disabled
    wr8(7'h29, 8'h0);
    wr8(7'h49, 8'h0);
    wr24(7'h2a, 24'h3);
    wr24(7'h30, 24'h2);
    wr24(7'h33, 24'h1);
    for (int k = 0; k < 5; k++)
    begin
      c2 = 6'($urandom);
      c3 = 6'($urandom);
      sl = (k == 4) ? 3 : k;
      n = (sl < 2) ? 0 : sl - 1;
      wr8(7'h36, 8'(sl));
      wr8(7'h59, {2'b01, c2});
      wr8(7'h5a, {1'b0, k < 4, c3});
      frame(0, 0, 1'b0);
      check_count(clamp_len, (k == 4) ? HOLD : n * HOLD);
      check_count(even_len, 387);
      if (n > 0 && k < 4)
        check_byte({2'b0, last_level}, {2'b0, (n == 2) ? c3 : c2});
    end
    // Trigger frames: the odd start lags the even one only when interleaved
    wr8(7'h36, 8'h1);
    for (int m = 0; m < 4; m++)
    begin
      g1 = $urandom % 20;
      g2 = $urandom % 20;
      wr8(7'h29, {6'h0, m[0], 1'b1});
      frame(g1, g2, 1'b1);
      check_count(even_len - odd_len, m[0] ? g1 + 3 : 0);
    end
    results();
  end
endmodule : testbench
